// ---- design/kwf_port.sv ----
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module kwf_port (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_key_wakeup_input,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_wakeup_irq,
	output logic o_irq,
	output logic o_osc_running
);
	// Pin synchronisers
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] prev_reg;
	// Registers
	logic [7:0] wakeup_flags_port_h_reg;
	logic [7:0] enable_reg;
	logic stop_reg;
	logic [7:0] osc_div_reg;
	logic [7:0] irq_status_reg;
	logic [7:0] irq_mask_reg;
	logic [7:0] rdata_reg;
	logic wakeup_irq_reg;
	logic irq_reg;
	// Filter oscillator
	kwf_pkg::kwf_osc_state_type osc_state_reg;
	kwf_pkg::kwf_osc_state_type osc_state_next;
	logic [7:0] osc_cnt_reg;
	logic [1:0] phase_reg;
	logic [3:0] idle_reg;
	logic [7:0] voted;

	// Address decode
	wire wr_flags = i_wr && (i_addr == kwf_pkg::FLAGS_OFFSET);
	wire wr_enable = i_wr && (i_addr == kwf_pkg::ENABLE_OFFSET);
	wire wr_ctrl = i_wr && (i_addr == kwf_pkg::CTRL_OFFSET);
	wire wr_mask = i_wr && (i_addr == kwf_pkg::IRQ_MASK_OFFSET);
	wire rd_status = i_rd && (i_addr == kwf_pkg::IRQ_STATUS_OFFSET);

	// Edge detection on synchronised pins
	wire [7:0] falling = prev_reg & ~sync2_reg;
	wire [7:0] trigger = falling & enable_reg;
	wire [7:0] asserted = ~sync2_reg & enable_reg;

	// Oscillator timing: one tick per sample, three samples per period
	wire tick = (osc_state_reg == kwf_pkg::KWF_OSC_RUN) && (osc_cnt_reg == 8'h00);
	wire period_end = tick && (phase_reg == kwf_pkg::VOTE_SAMPLES - 2'h1);
	wire osc_start = stop_reg && (osc_state_reg == kwf_pkg::KWF_OSC_OFF) && (|trigger);

	// Flag set sources: direct edges outside STOP, voted levels in STOP
	wire [7:0] flag_set = stop_reg ? voted : falling;
	wire [7:0] flag_clr = wr_flags ? i_wdata : 8'h00;
	wire [7:0] flags_next = (wakeup_flags_port_h_reg & ~flag_clr) | flag_set;
	wire [7:0] irq_events = {6'h00, osc_start, |flag_set};
	wire [7:0] status_next = (rd_status ? 8'h00 : irq_status_reg) | irq_events;

	// Register read selection
	wire [7:0] ctrl_read = {7'h00, stop_reg};
	wire [7:0] rdata_next =
		!i_rd ? 8'h00 :
		(i_addr == kwf_pkg::FLAGS_OFFSET) ? wakeup_flags_port_h_reg :
		(i_addr == kwf_pkg::ENABLE_OFFSET) ? enable_reg :
		(i_addr == kwf_pkg::CTRL_OFFSET) ? ctrl_read :
		(i_addr == kwf_pkg::IRQ_STATUS_OFFSET) ? irq_status_reg :
		(i_addr == kwf_pkg::IRQ_MASK_OFFSET) ? irq_mask_reg : 8'h00;

	// Oscillator start and stop
	always_comb begin
		case (osc_state_reg)
			kwf_pkg::KWF_OSC_OFF: begin
				osc_state_next = osc_start ? kwf_pkg::KWF_OSC_RUN : kwf_pkg::KWF_OSC_OFF;
			end
			kwf_pkg::KWF_OSC_RUN: begin
				if (!stop_reg || (period_end && idle_reg >= kwf_pkg::OSC_IDLE_PERIODS)) begin
					osc_state_next = kwf_pkg::KWF_OSC_OFF;
				end else begin
					osc_state_next = kwf_pkg::KWF_OSC_RUN;
				end
			end
			default: begin
				osc_state_next = kwf_pkg::KWF_OSC_OFF;
			end
		endcase
	end

	// Two-flop synchroniser and edge history
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			sync1_reg <= 8'hff;
			sync2_reg <= 8'hff;
			prev_reg <= 8'hff;
		end else begin
			sync1_reg <= i_key_wakeup_input;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// Software registers
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wakeup_flags_port_h_reg <= kwf_pkg::FLAGS_RESET;
			enable_reg <= kwf_pkg::ENABLE_RESET;
			stop_reg <= 1'b0;
			osc_div_reg <= kwf_pkg::OSC_DIV_RESET;
			irq_status_reg <= 8'h00;
			irq_mask_reg <= kwf_pkg::MASK_RESET;
		end else begin
			wakeup_flags_port_h_reg <= flags_next;
			irq_status_reg <= status_next;
			if (wr_enable) begin
				enable_reg <= i_wdata;
			end
			if (wr_ctrl) begin
				stop_reg <= i_wdata[kwf_pkg::CTRL_STOP_BIT];
			end
			if (wr_ctrl && i_wdata[kwf_pkg::CTRL_STOP_BIT + 1]) begin
				osc_div_reg <= i_wdata;
			end
			if (wr_mask) begin
				irq_mask_reg <= i_wdata;
			end
		end
	end

	// Filter oscillator divider, sample phase and idle counter
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || osc_state_reg == kwf_pkg::KWF_OSC_OFF) begin
			osc_cnt_reg <= 8'h00;
			phase_reg <= 2'h0;
			idle_reg <= 4'h0;
		end else begin
			osc_cnt_reg <= (osc_cnt_reg == 8'h00) ? osc_div_reg : osc_cnt_reg - 8'h01;
			if (period_end) begin
				phase_reg <= 2'h0;
				// Any low enabled pin keeps it alive; a short high gap does not end a pulse
				idle_reg <= (|asserted) ? 4'h0 : idle_reg + 4'h1;
			end else if (tick) begin
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end

	// State and output registers
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			osc_state_reg <= kwf_pkg::KWF_OSC_OFF;
			rdata_reg <= 8'h00;
			wakeup_irq_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			osc_state_reg <= osc_state_next;
			rdata_reg <= rdata_next;
			wakeup_irq_reg <= |(flags_next & enable_reg);
			irq_reg <= |(status_next & irq_mask_reg);
		end
	end

	// Shared majority voter for all pins
	kwf_vote u_vote (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_sample(tick),
		.i_period_end(period_end),
		.i_pins(sync2_reg),
		.i_enable(enable_reg),
		.o_valid(voted)
	);

	assign o_rdata = rdata_reg;
	assign o_wakeup_irq = wakeup_irq_reg;
	assign o_irq = irq_reg;
	assign o_osc_running = (osc_state_reg == kwf_pkg::KWF_OSC_RUN);
endmodule

// ---- pkg/kwf_pkg.sv ----
package kwf_pkg;
	// Register offsets
	localparam logic [7:0] FLAGS_OFFSET = 8'h2f;
	localparam logic [7:0] ENABLE_OFFSET = 8'h2e;
	localparam logic [7:0] CTRL_OFFSET = 8'h2d;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h2c;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h2b;
	// Control register field positions
	localparam int CTRL_STOP_BIT = 0;
	localparam int CTRL_OSC_DIV_LSB = 8;
	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] OSC_DIV_RESET = 8'h10;
	// Interrupt status bit positions
	localparam int IRQ_FLAG_EVENT_BIT = 0;
	localparam int IRQ_OSC_START_BIT = 1;
	// Filter timing: three samples per oscillator period, two to accept
	localparam logic [1:0] VOTE_SAMPLES = 2'h3;
	localparam logic [1:0] VOTE_MAJORITY = 2'h2;
	// Oscillator idle periods before stopping
	localparam logic [3:0] OSC_IDLE_PERIODS = 4'h2;
	// Filter state machine
	typedef enum logic [1:0] {
		KWF_OSC_OFF = 2'b00,
		KWF_OSC_RUN = 2'b01
	} kwf_osc_state_type;
endpackage

// ---- design/kwf_vote.sv ----
`timescale 1ns/1ps
// Majority voter: counts low samples per pin over the first two of three sample strobes
module kwf_vote (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_sample,
	input wire logic i_period_end,
	input wire logic [7:0] i_pins,
	input wire logic [7:0] i_enable,
	output logic [7:0] o_valid
);
	logic [1:0] count_reg [8];
	logic [7:0] valid_reg;
	logic [7:0] valid_next;

	// Accept a pin when the first two of three samples were both low
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			valid_next[i] = i_period_end && i_enable[i] && (count_reg[i] >= kwf_pkg::VOTE_MAJORITY);
		end
	end

	// Per pin low-sample counters, cleared at each period end
	always_ff @(posedge i_sys_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (i_reset || i_period_end) begin
				count_reg[i] <= 2'h0;
			end else if (i_sample && !i_pins[i] && count_reg[i] != kwf_pkg::VOTE_SAMPLES) begin
				count_reg[i] <= count_reg[i] + 2'h1;
			end
		end
		if (i_reset) begin
			valid_reg <= 8'h00;
		end else begin
			valid_reg <= valid_next;
		end
	end

	assign o_valid = valid_reg;
endmodule

// ---- testbench/kwf_pins.sv ----
`timescale 1ns/1ps
// Switch bank; pull-ups hold idle lines high
module kwf_pins (
	input wire logic i_sys_clk,
	output logic [7:0] o_pins
);
	initial o_pins = 8'hff;
	// Hold line n low for w clocks, then release
	task automatic press(input int n, input int w);
		@(posedge i_sys_clk);
		o_pins[n] <= 1'b0;
		repeat (w) @(posedge i_sys_clk);
		o_pins[n] <= 1'b1;
	endtask
endmodule

// ---- testbench/kwf_port_sva.sv ----
`timescale 1ns/1ps
module kwf_chk (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_key_wakeup_input,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_wakeup_irq,
	input wire logic o_irq,
	input wire logic o_osc_running
);
	logic stop_reg;
	logic [7:0] en_reg;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// Shadow of STOP and enable bits
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			stop_reg <= 1'b0;
			en_reg <= 8'h00;
		end else if (i_wr && i_addr == 8'h2d) begin
			stop_reg <= i_wdata[0];
		end else if (i_wr && i_addr == 8'h2e) begin
			en_reg <= i_wdata;
		end
	end
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside answer");
	unmapped_read_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (i_rd && i_addr == 8'h2d |=> o_rdata == {7'h00, stop_reg})
		else $error("control read wrong");
	reset_quiet_a: assert property ($fell(i_reset) |-> !(o_irq || o_wakeup_irq || o_osc_running))
		else $error("outputs high after reset");
	clear_drop_a: assert property ((&i_key_wakeup_input && !o_osc_running) [*4] ##0
		(i_wr && i_addr == 8'h2f && i_wdata == 8'hff) |=> ##1 !o_wakeup_irq)
		else $error("flags not cleared");
	stop_osc_a: assert property (!stop_reg [*3] |-> !o_osc_running)
		else $error("oscillator outside stop");
	wake_en_a: assert property (o_wakeup_irq |-> $past(en_reg) != 8'h00)
		else $error("wake request without enable");
	osc_start_a: assert property ($rose(o_osc_running) |-> $past(stop_reg) && $past(en_reg) != 8'h00)
		else $error("oscillator start unexpected");
	cover property ($rose(o_osc_running));
	cover property ($rose(o_wakeup_irq));
	cover property ($fell(o_irq));
endmodule
bind kwf_port kwf_chk kwf_chk_inst (.i_sys_clk, .i_reset, .i_key_wakeup_input, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .o_wakeup_irq, .o_irq, .o_osc_running);

// ---- testbench/kwf_port_tb.sv ----
`timescale 1ns/1ps
module kwf_port_tb;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] pins;
	logic [7:0] o_rdata;
	logic o_wakeup_irq, o_irq, o_osc_running;
	logic [7:0] regs [6] = '{8'h2f, 8'h2e, 8'h2d, 8'h2c, 8'h2b, 8'h00};
	int miscompares = 0;
	int n_checks = 0;
	kwf_pins kwf_pins_inst (.i_sys_clk(i_sys_clk), .o_pins(pins));
	kwf_port kwf_port_inst (.i_sys_clk, .i_reset, .i_key_wakeup_input(pins), .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .o_wakeup_irq, .o_irq, .o_osc_running);
	initial forever #5 i_sys_clk = ~i_sys_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		cyc(1);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cyc(1);
		i_rd <= 1'b1;
		i_addr <= a;
		cyc(1);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
	initial begin
		cyc(5);
		i_reset <= 1'b0;
		foreach (regs[k]) rd(regs[k], 8'h00);
		// Each pin outside STOP; zero write keeps, one write clears
		for (int i = 0; i < 8; i++) begin
			kwf_pins_inst.press(i, 3);
			cyc(5);
			rd(8'h2f, 8'h01 << i);
			wr(8'h2f, ~(8'h01 << i));
			rd(8'h2f, 8'h01 << i);
			wr(8'h2f, 8'h01 << i);
		end
		// Enabled flag raises both requests; status read clears
		wr(8'h2e, 8'h01);
		wr(8'h2b, 8'h01);
		kwf_pins_inst.press(0, 3);
		cyc(6);
		#1 chk({6'h00, o_irq, o_wakeup_irq}, 8'h03);
		rd(8'h2c, 8'h01);
		wr(8'h2f, 8'hff);
		cyc(2);
		#1 chk({6'h00, o_irq, o_wakeup_irq}, 8'h00);
		// STOP: short pulse filtered, disabled pin ignored
		wr(8'h2d, 8'h01);
		rd(8'h2d, 8'h01);
		kwf_pins_inst.press(0, 2);
		cyc(4);
		#1 chk({7'h00, o_osc_running}, 8'h01);
		cyc(300);
		rd(8'h2f, 8'h00);
		#1 chk({6'h00, o_irq, o_osc_running}, 8'h00);
		kwf_pins_inst.press(1, 200);
		#1 chk({7'h00, o_osc_running}, 8'h00);
		rd(8'h2f, 8'h00);
		// Two long presses with a one-clock gap
		kwf_pins_inst.press(0, 60);
		kwf_pins_inst.press(0, 60);
		cyc(100);
		rd(8'h2f, 8'h01);
		rd(8'h2c, 8'h03);
		wr(8'h2d, 8'h00);
		cyc(3);
		#1 chk({7'h00, o_osc_running}, 8'h00);
		give_verdict();
	end
endmodule
